// file: common/ubg_pkg.sv
package ubg_pkg;

    // Clocking mode of the bit-rate generator.
    typedef enum logic [1:0] {
        UBG_ASYNC,
        UBG_SYNC_INT,
        UBG_SYNC_EXT
    } ubg_mode_e;

    typedef logic [4:0] ubg_phase_t;

endpackage

// file: common/ubg_regs.svh
// Operation
// RL1: With the sample-mode bit at 0 the block picks the sample position, at 1 the sample-position register sets it.
// RL2: The position field names the oversample period, from 0 up to 15, that holds the first of three samples.
// RL3: Software keeps the position field at or below the oversample rate minus 3.
// RL4: The sample-position register is 8 bits, read/write, field in bits 3 to 0, reset value 6.
// RL5: Automatic positions are 2,3,4 / 3,4,5 / 4,5,6 / 5,6,7 / 6,7,8 for rates 7-8 / 9-10 / 11-12 / 13-14 / 15-16.
// RL6: Each received bit is the majority of its three samples.
// RL7: In manual mode the three samples start at the programmed position.
// RL8: The asynchronous bit rate is the clock over oversample rate times divisor plus 1 times prescaler.
// RL9: The prescaler offers half-step factors such as 6.5 and 9.5.
// RL10: Software keeps the baud-rate error at or below 3 percent.
// RL11: Synchronous mode exists on the first channel only.
// RL12: Synchronous mode with the clock-source bit set shifts on the clock from the sync clock pin.
// RL13: Synchronous mode with the clock-source bit clear uses the internal generator and drives it on the pin.
// RL14: The internal synchronous rate is the clock over 2 times divisor plus 1 times prescaler.
// RL15: Software picks only integer prescaler factors in synchronous mode.
// RL16: Oversample codes 0 to 6 give 16x, codes 7 to 15 give the code value.
`ifndef UBG_REGS_SVH
`define UBG_REGS_SVH

`define UBG_OFS_OVR      8'h00
`define UBG_OFS_PSR      8'h04
`define UBG_OFS_BAUD     8'h08
`define UBG_OFS_MODE     8'h0C
`define UBG_OFS_SPOS     8'h10
`define UBG_OFS_SYNC     8'h14
`define UBG_OFS_STAT     8'h18

`define UBG_RST_OVR      4'h0
`define UBG_RST_PSR      5'h00
`define UBG_RST_BAUD     16'h0000
`define UBG_RST_MODE     1'b0
`define UBG_RST_SPOS     4'h6

`define UBG_BIT_SMODE    0
`define UBG_BIT_SYNC_EN  0
`define UBG_BIT_CKSRC    1

`define UBG_OVS_DEFAULT  5'h10
`define UBG_OVS_MIN_CODE 4'h7
`define UBG_PSR_OFFSET   6'h02
`define UBG_PSR_STEP     6'h02

`endif

// file: design/ubg_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_sampler (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       os_tick,
    input  wire logic       align,
    input  wire logic [4:0] os_rate,
    input  wire logic [3:0] start_pos,
    input  wire logic       rxd,
    output logic [4:0]      phase,
    output logic            bit_tick,
    output logic            bit_val,
    output logic            bit_valid
);

    // Majority of three samples.
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    logic [4:0] phase_r;
    logic [4:0] phase_nxt;
    logic [1:0] smp_r;
    logic       val_r;
    logic       valid_r;
    logic       wrap;
    logic       last_hit;

    ////////////////////////////////////////////////////////////////////////
    // Phase within the bit period, one step per oversample tick.
    assign wrap      = (phase_r >= os_rate - 5'd1);
    assign phase_nxt = wrap ? 5'd0 : phase_r + 5'd1;
    assign last_hit  = os_tick & (phase_r == {1'b0, start_pos} + 5'd2); // RL2

    always_ff @(posedge clk) begin
        if (!nrst || align) begin
            phase_r <= 5'd0;
        end else if (os_tick) begin
            phase_r <= phase_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The first two samples are held until the third one arrives.
    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_smp
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    smp_r[k] <= 1'b1;
                end else if (os_tick &&
                             phase_r == {1'b0, start_pos} + 5'(k)) begin
                    smp_r[k] <= rxd; // RL2
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Third sample completes the vote.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            val_r   <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            valid_r <= last_hit;
            if (last_hit) begin
                val_r <= maj3(smp_r[0], smp_r[1], rxd); // RL6
            end
        end
    end

    assign phase     = phase_r;
    assign bit_tick  = os_tick & wrap & ~align;
    assign bit_val   = val_r;
    assign bit_valid = valid_r;

endmodule
`default_nettype wire

// file: design/ubg_top.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubg_regs.svh"
module ubg_top #(
    parameter bit FIRST_CHANNEL = 1'b1
) (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RXD,
    input  wire logic        BIT_ALIGN,
    input  wire logic        SYNC_CLOCK_PIN_I,
    output logic             SYNC_CLOCK_PIN_O,
    output logic             SYNC_CLOCK_PIN_OE,
    output logic             OS_TICK,
    output logic             BIT_TICK,
    output logic             RX_BIT,
    output logic             RX_BIT_VALID
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding functions.

    // Oversample code to rate: low codes mean 16x.
    function automatic logic [4:0] ovs_rate(input logic [3:0] code);
        if (code < `UBG_OVS_MIN_CODE) begin
            ovs_rate = `UBG_OVS_DEFAULT;
        end else begin
            ovs_rate = {1'b0, code};
        end
    endfunction

    // Automatic first-sample position, roughly centred in the bit.
    // Half of the rate minus three puts the middle sample at most one
    // period before the centre of the bit for every rate from 7 to 16.
    function automatic logic [3:0] auto_pos(input logic [4:0] rate);
        logic [4:0] t;
        t = (rate - 5'd3) >> 1;
        auto_pos = t[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register storage. Only the field bits are kept; the rest of each
    // word reads back as zero.
    logic [3:0]  ovr_r;
    logic [4:0]  psr_r;
    logic [15:0] baud_r;
    logic        smode_r;
    logic [3:0]  spos_r;
    logic        sync_en_r;
    logic        cksrc_r;

    // Generator state.
    logic [5:0]  pacc_r;
    logic [5:0]  pacc_nxt;
    logic        ptick;
    logic [15:0] dcnt_r;
    logic        dtick;
    logic        sclk_r;
    logic        ckx_prev_r;
    logic        sbit_r;
    logic        svalid_r;

    // Decode wires.
    logic        wr_en;
    logic        rd_en;
    logic        gen_restart;
    logic        hit_ovr;
    logic        hit_psr;
    logic        hit_baud;
    logic        hit_mode;
    logic        hit_spos;
    logic        hit_sync;
    logic        hit_stat;
    logic        hit_any;
    logic [5:0]  p_half;
    logic [5:0]  pacc_inc;
    logic [4:0]  rate;
    logic [3:0]  start_pos;
    logic        sync_ok;
    logic        sync_tick;
    logic        os_tick;
    logic        a_tick;
    logic        a_val;
    logic        a_valid;
    logic [4:0]  phase;
    logic [31:0] rd_mux;

    ubg_pkg::ubg_mode_e mode;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped addresses. Reads are
    // looked up in the setup phase, so the data already stands when the
    // master samples the access phase with PREADY high.
    assign hit_ovr  = (PADDR == `UBG_OFS_OVR);
    assign hit_psr  = (PADDR == `UBG_OFS_PSR);
    assign hit_baud = (PADDR == `UBG_OFS_BAUD);
    assign hit_mode = (PADDR == `UBG_OFS_MODE);
    assign hit_spos = (PADDR == `UBG_OFS_SPOS);
    assign hit_sync = (PADDR == `UBG_OFS_SYNC);
    assign hit_stat = (PADDR == `UBG_OFS_STAT);
    assign hit_any  = hit_ovr | hit_psr | hit_baud | hit_mode |
                      hit_spos | hit_sync | hit_stat;
    assign wr_en    = PSEL & PENABLE & PWRITE & hit_any;
    assign rd_en    = PSEL & ~PENABLE & ~PWRITE;
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL & PENABLE & ~hit_any;

    // Writes to the configuration registers.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ovr_r     <= `UBG_RST_OVR;
            psr_r     <= `UBG_RST_PSR;
            baud_r    <= `UBG_RST_BAUD;
            smode_r   <= `UBG_RST_MODE;
            spos_r    <= `UBG_RST_SPOS; // RL4
            sync_en_r <= 1'b0;
            cksrc_r   <= 1'b0;
        end else if (wr_en) begin
            if (hit_ovr) begin
                ovr_r <= PWDATA[3:0];
            end
            if (hit_psr) begin
                psr_r <= PWDATA[4:0];
            end
            if (hit_baud) begin
                baud_r <= PWDATA[15:0];
            end
            if (hit_mode) begin
                smode_r <= PWDATA[`UBG_BIT_SMODE];
            end
            if (hit_spos) begin
                spos_r <= PWDATA[3:0]; // RL4
            end
            if (hit_sync) begin
                // Only the first channel can hold synchronous mode.
                sync_en_r <= PWDATA[`UBG_BIT_SYNC_EN] & FIRST_CHANNEL; // RL11
                cksrc_r   <= PWDATA[`UBG_BIT_CKSRC] & FIRST_CHANNEL;
            end
        end
    end

    // Read data selection; unused bits read as zero.
    assign rd_mux =
        hit_ovr  ? {28'h000_0000, ovr_r} :
        hit_psr  ? {27'h000_0000, psr_r} :
        hit_baud ? {16'h0000, baud_r} :
        hit_mode ? {31'h0000_0000, smode_r} :
        hit_spos ? {28'h000_0000, spos_r} : // RL4
        hit_sync ? {30'h0000_0000, cksrc_r, sync_en_r} :
        hit_stat ? {23'h00_0000, phase, sclk_r, svalid_r, RX_BIT, a_val} :
                   32'h0000_0000;

    // Read data is registered in the setup phase and then held, so it
    // stands through the access phase and stays stable after it.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            PRDATA <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode selection from the synchronous control bits. The channel
    // parameter is applied here as well as at the write, so a channel
    // built without synchronous support can never leave asynchronous mode.
    assign sync_ok = sync_en_r & FIRST_CHANNEL; // RL11
    assign mode = !sync_ok ? ubg_pkg::UBG_ASYNC :
                  cksrc_r  ? ubg_pkg::UBG_SYNC_EXT :
                             ubg_pkg::UBG_SYNC_INT;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler in half steps: factor is (code + 2) / 2, so odd codes give
    // x.5 factors. Each cycle adds two halves; a tick fires when the sum
    // reaches the factor, and the remainder carries over. The tick spacing
    // then jitters by one cycle but averages to the exact factor.
    // A new prescaler or divisor value restarts both counters, so the
    // first tick after the change already has the new spacing instead
    // of draining whatever the old setting left in the accumulator.
    assign gen_restart = wr_en & (hit_psr | hit_baud);

    assign p_half   = {1'b0, psr_r} + `UBG_PSR_OFFSET;
    assign pacc_inc = pacc_r + `UBG_PSR_STEP;
    assign ptick    = (pacc_inc >= p_half); // RL9
    assign pacc_nxt = ptick ? pacc_inc - p_half : pacc_inc;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pacc_r <= 6'h00;
        end else if (gen_restart) begin
            pacc_r <= 6'h00;
        end else begin
            pacc_r <= pacc_nxt; // RL9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divisor: one tick every divisor plus 1 prescaler ticks. The compare
    // is greater-or-equal; lowering the divisor restarts the count at zero,
    // so the count never stands above it and the new interval runs in full.
    assign dtick = ptick & (dcnt_r >= baud_r); // RL8

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            dcnt_r <= 16'h0000;
        end else if (gen_restart) begin
            dcnt_r <= 16'h0000;
        end else if (ptick) begin
            dcnt_r <= dtick ? 16'h0000 : dcnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous sampling: divisor ticks are oversample clocks.
    assign rate      = ovs_rate(ovr_r); // RL16
    assign start_pos = smode_r ? spos_r : auto_pos(rate); // RL1 RL5 RL7
    assign os_tick   = dtick & (mode == ubg_pkg::UBG_ASYNC); // RL8

    // A manual position above the rate minus three never reaches its
    // third sample before the phase wraps, so such a setting simply
    // delivers no bits; software has to keep within that limit.
    ubg_sampler u_sampler (
        .clk       (CLK),
        .nrst      (NRST),
        .os_tick   (os_tick),
        .align     (BIT_ALIGN),
        .os_rate   (rate),
        .start_pos (start_pos),
        .rxd       (RXD),
        .phase     (phase),
        .bit_tick  (a_tick),
        .bit_val   (a_val),
        .bit_valid (a_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Internal synchronous clock toggles on every divisor tick, giving a
    // full period of twice the divided interval with no oversampling.
    // It idles high outside internal synchronous mode, so the first
    // divisor tick after entry gives a falling edge, never a short high.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sclk_r <= 1'b1;
        end else if (mode != ubg_pkg::UBG_SYNC_INT) begin
            sclk_r <= 1'b1;
        end else if (dtick) begin
            sclk_r <= ~sclk_r; // RL14
        end
    end

    // Previous level of the sync clock pin, for edge detection. It resets
    // to the idle high level of the pin, so no false rising edge is seen
    // as soon as reset ends.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ckx_prev_r <= 1'b1;
        end else begin
            ckx_prev_r <= SYNC_CLOCK_PIN_I;
        end
    end

    // Data is taken on the rising edge of whichever clock is chosen.
    assign sync_tick =
        (mode == ubg_pkg::UBG_SYNC_INT) ? (dtick & ~sclk_r) : // RL13 RL14
        (mode == ubg_pkg::UBG_SYNC_EXT) ?
            (SYNC_CLOCK_PIN_I & ~ckx_prev_r) : // RL12
            1'b0;

    // Synchronous receive bit capture; the data line is taken in the
    // same cycle in which the rising clock edge is recognised.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sbit_r   <= 1'b1;
            svalid_r <= 1'b0;
        end else begin
            svalid_r <= sync_tick;
            if (sync_tick) begin
                sbit_r <= RXD; // RL12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: the internal clock goes out only when it is the source.
    assign SYNC_CLOCK_PIN_O  = sclk_r;
    assign SYNC_CLOCK_PIN_OE = (mode == ubg_pkg::UBG_SYNC_INT); // RL13

    // Outputs toward the framing logic. The synchronous path takes over
    // all three bit outputs whenever synchronous mode is on, so the
    // framing logic never mixes bits from the two sampling schemes.
    assign OS_TICK      = os_tick;
    assign BIT_TICK     = sync_ok ? sync_tick : a_tick;
    assign RX_BIT       = sync_ok ? sbit_r : a_val;
    assign RX_BIT_VALID = sync_ok ? svalid_r : a_valid;

endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubg_regs.svh"
module testbench;
    logic        clk, nrst, psel, penable, pwrite, play, ext_on, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [15:0] shape;
    logic [4:0]  len;
    wire  logic [31:0] prdata;
    wire  logic  pready, slverr, rxd, algn, sck, sck_o, oe, ost, btk, rxb, rxv;
    int          err_total, checks, cyc;
    logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    logic [31:0] rv [6] = '{32'h0000_000F, 32'h0000_001F, 32'h0000_FFFF,
                            32'h0000_0001, 32'h0000_000F, 32'h0000_0000};
    logic [31:0] bm [4] = '{0, 0, 1, 0};
    logic [31:0] bp [4] = '{0, 0, 2, 0};
    logic [31:0] bo [4] = '{0, 0, 0, 7};
    logic [15:0] bs [4] = '{16'h00C0, 16'h0700, 16'h001C, 16'h000C};
    logic [4:0]  bl [4] = '{16, 16, 16, 7};
    logic [31:0] be [4] = '{1, 0, 1, 1};
    logic [31:0] ro [6] = '{0, 7, 3, 9, 0, 0};
    logic [31:0] rp [6] = '{0, 0, 1, 11, 0, 0};
    logic [31:0] rb [6] = '{0, 1, 2, 0, 1, 0};
    logic [31:0] rs [6] = '{0, 0, 0, 0, 1, 3};
    logic [31:0] re [6] = '{32, 28, 144, 117, 8, 12};
    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ubg_top uut (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(slverr), .RXD(rxd), .BIT_ALIGN(algn),
        .SYNC_CLOCK_PIN_I(sck), .SYNC_CLOCK_PIN_O(sck_o),
        .SYNC_CLOCK_PIN_OE(oe), .OS_TICK(ost), .BIT_TICK(btk),
        .RX_BIT(rxb), .RX_BIT_VALID(rxv)
    );
    ubg_remote u_remote (
        .clk(clk), .play(play), .shape(shape), .len(len),
        .ext_on(ext_on), .rxd(rxd), .align(algn), .sck(sck)
    );
    //////////////////////////////////////////
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus transfer; read data and error are taken at the access edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        er = slverr;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles from the second to the fourth bit tick.
    task automatic meas();
        int k;
        k = 0;
        cyc = 0;
        while (k < 4 && cyc < 3000) begin
            @(posedge clk);
            if (btk === 1'b1) k++;
            if (k > 1) cyc++;
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    // Register, sampling and rate scenarios.
    initial begin
        {nrst, psel, penable, pwrite, play, ext_on} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        shape = 16'h0000;
        len = 5'h10;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, (i == 4) ? 32'h0000_0006 : 32'h0000_0000);
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ra[i], 32'hFFFF_FFFF);
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
            chk({31'h0, er}, {31'h0, i == 5});
        end
        apb(1'b1, `UBG_OFS_PSR, 32'h0);
        apb(1'b1, `UBG_OFS_BAUD, 32'h0);
        apb(1'b1, `UBG_OFS_SYNC, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `UBG_OFS_MODE, bm[i]);
            apb(1'b1, `UBG_OFS_SPOS, bp[i]);
            apb(1'b1, `UBG_OFS_OVR, bo[i]);
            @(posedge clk);
            shape <= bs[i];
            len   <= bl[i];
            play  <= 1'b1;
            @(posedge clk);
            play <= 1'b0;
            repeat (3) @(posedge clk);
            for (int k = 0; k < 100 && rxv !== 1'b1; k++) @(posedge clk);
            chk({31'h0, rxb}, be[i]);
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `UBG_OFS_OVR, ro[i]);
            apb(1'b1, `UBG_OFS_PSR, rp[i]);
            apb(1'b1, `UBG_OFS_BAUD, rb[i]);
            @(posedge clk);
            ext_on <= (rs[i] == 3);
            apb(1'b1, `UBG_OFS_SYNC, rs[i]);
            meas();
            chk(32'(cyc - 1), re[i]);
            chk({31'h0, oe}, {31'h0, rs[i] == 1});
        end
        apb(1'b0, `UBG_OFS_SYNC, 32'h0);
        chk(rd, 32'h0000_0003);
        chk({31'h0, sck_o}, 32'h0000_0001);
        print_verdict();
    end
endmodule
`default_nettype wire

// file: testbench/ubg_remote.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_remote (
    input  wire logic        clk,
    input  wire logic        play,
    input  wire logic [15:0] shape,
    input  wire logic [4:0]  len,
    input  wire logic        ext_on,
    output logic             rxd,
    output logic             align,
    output logic             sck
);
    logic [4:0] cnt_r;
    logic       busy_r;
    logic [1:0] div_r;
    // Line idles at mark, clock idles high.
    initial begin
        rxd = 1'b1;
        align = 1'b0;
        sck = 1'b1;
        busy_r = 1'b0;
    end
    // Plays one bit, one level per oversample period, after a restart.
    always @(posedge clk) begin
        align <= play;
        if (play) begin
            cnt_r  <= 5'h00;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            rxd    <= shape[cnt_r[3:0]];
            cnt_r  <= cnt_r + 5'h01;
            busy_r <= (cnt_r != len - 5'h01);
        end else begin
            rxd <= 1'b1;
        end
    end
    // External clock toggles every third cycle, stands still otherwise.
    always @(posedge clk) begin
        if (!ext_on) begin
            div_r <= 2'h0;
            sck   <= 1'b1;
        end else if (div_r == 2'h2) begin
            div_r <= 2'h0;
            sck   <= !sck;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/ubg_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubg_regs.svh"
module ubg_top_chk (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SYNC_CLOCK_PIN_O,
    input wire logic        SYNC_CLOCK_PIN_OE,
    input wire logic        OS_TICK,
    input wire logic        BIT_TICK,
    input wire logic        RX_BIT,
    input wire logic        RX_BIT_VALID
);
    // Access phases of the register bus.
    wire logic acc     = PSEL && PENABLE;
    wire logic rd_acc  = acc && !PWRITE;
    wire logic rd_set  = PSEL && !PENABLE && !PWRITE;
    wire logic sync_wr = acc && PWRITE && (PADDR == `UBG_OFS_SYNC);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_spos_rd;
        rd_acc && (PADDR == `UBG_OFS_SPOS);
    endsequence
    sequence s_sck_rise;
        SYNC_CLOCK_PIN_OE && $rose(SYNC_CLOCK_PIN_O);
    endsequence
    //////////////////////////////////////////
    AST_PREADY_ACC: assert property (acc |-> PREADY)
        else $error("PREADY low in access phase");
    AST_SLVERR_PHASE: assert property (PSLVERR |-> acc)
        else $error("PSLVERR outside access phase");
    AST_SPOS_RSVD: assert property (s_spos_rd |-> PRDATA[31:4] == 28'h0)
        else $error("position register upper bits set");
    AST_PRDATA_HOLD: assert property ($changed(PRDATA) |-> $past(rd_set))
        else $error("read data changed without a read");
    AST_VALID_PULSE: assert property (RX_BIT_VALID |=> !RX_BIT_VALID)
        else $error("bit valid longer than one cycle");
    AST_BIT_HOLD: assert property (!RX_BIT_VALID |-> $stable(RX_BIT))
        else $error("received bit changed without valid");
    AST_OS_ASYNC: assert property (OS_TICK |-> !SYNC_CLOCK_PIN_OE)
        else $error("oversample tick in sync mode");
    AST_OE_BY_WR: assert property ($changed(SYNC_CLOCK_PIN_OE) |->
        $past(sync_wr) || $past(sync_wr, 2))
        else $error("clock pin enable changed without write");
    AST_SYNC_TICK: assert property (s_sck_rise |-> $past(BIT_TICK))
        else $error("no bit tick at sync clock rise");
endmodule
bind ubg_top ubg_top_chk u_chk (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SYNC_CLOCK_PIN_O(SYNC_CLOCK_PIN_O),
    .SYNC_CLOCK_PIN_OE(SYNC_CLOCK_PIN_OE), .OS_TICK(OS_TICK),
    .BIT_TICK(BIT_TICK), .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID)
);
`default_nettype wire
